/* hdl/ssc_top.sv */
// The register offsets and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ns
// Notes on behaviour
// - after reset the node runs normal, never sleeping, until a sleep mode is set.
// - modes 7 and 8 are the synchronous sleep compatible modes.
// - option bit 0 makes the node a preferred coordinator.
// - double button press makes the node a coordinator that sends syncs.
// - as coordinator the association indicator blinks slowly.
// - indicator blinks while awake and synchronised.
// - single press wakes a sleeping synchronised node.
// - unsynced node sends sync request, sleeps its period, repeats until synced.
// - awake synced node answers each sync request with a sync.
// - support mode node stays awake always and answers requests.
// - button hold wakes cyclic node for 30 s, answering requests.
// - changing periods away from network values makes node coordinator unless barred.
// - coordinator sends new settings at next wake start; receivers adopt them at once.
// - missing the new-settings sync keeps the previous operating periods.
// - early wake, default on, shortens sleep by missed sync count.
// - support node rejects sync with older settings and answers with newer ones.
// - mode 8 selects synchronous cyclic sleep.
// - operating sleep and wake periods are readable.
// - status shows whether node is acting coordinator.
// - count of cycles since last sync is readable.
// - status message option emits a frame on wake and just before sleep.
// - eligible node nominates itself after three or more missed syncs.
// - claim priority: newer params, preferred, support node, higher serial.
module ssc_top
    import ssc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC,
    parameter int HOLD_TICKS  = AWAKE_TICKS
) (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // classic wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // button events, already debounced, asynchronous levels from pins
    input  wire logic        btn_single_i,
    input  wire logic        btn_double_i,
    input  wire logic        btn_hold_i,
    // sync messages received from peers, one-cycle pulses from the mac
    input  wire logic        rx_req_i,
    input  wire logic        rx_sync_i,
    input  wire logic        rx_sync_coord_i,
    input  wire logic [15:0] rx_sleep_i,
    input  wire logic [15:0] rx_wake_i,
    input  wire logic [7:0]  rx_gen_i,
    input  wire logic        rx_pref_i,
    input  wire logic        rx_support_i,
    input  wire logic [15:0] rx_serial_i,
    // messages to send
    output logic             tx_req_o,
    output logic             tx_sync_o,
    output logic      [15:0] tx_sleep_o,
    output logic      [15:0] tx_wake_o,
    output logic      [7:0]  tx_gen_o,
    output logic             stat_wake_o,
    output logic             stat_sleep_o,
    output logic             awake_o,
    output logic             led_o
);
    import ssc_pkg::*;

    // reset release synchroniser
    logic rst_m_q, rst_n_q;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_m_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_n_q <= rst_m_q;
        end
    end

    // button pin synchronisers; the first stage feeds the second only
    logic [2:0] btn_m_q, btn_s_q, btn_p_q;
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            btn_m_q <= 3'b000;
            btn_s_q <= 3'b000;
            btn_p_q <= 3'b000;
        end else begin
            btn_m_q <= {btn_hold_i, btn_double_i, btn_single_i};
            btn_s_q <= btn_m_q;
            btn_p_q <= btn_s_q;
        end
    end
    wire [2:0] btn_ev = btn_s_q & ~btn_p_q;
    wire       press1 = btn_ev[0];
    wire       press2 = btn_ev[1];
    wire       hold   = btn_ev[2];

    // software registers
    logic [3:0]  mode_q;
    logic [3:0]  opts_q;
    logic [15:0] sp_q, st_q, osp_q, owk_q;
    logic [15:0] serial_q;
    logic [7:0]  gen_q, missed_q;
    logic        coord_q, synced_q, pending_q;
    ssc_state_t  state_q;

    wire compat   = (mode_q == MODE_SUPPORT) || (mode_q == MODE_CYCLIC);
    wire cyclic   = (mode_q == MODE_CYCLIC);
    wire support  = (mode_q == MODE_SUPPORT);
    wire pref     = opts_q[OPT_PREF];
    wire noncoord = opts_q[OPT_NONCOORD];

    // bus decode; one wait state, ack drops after one cycle
    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr_en   = bus_req && wb_we_i;
    wire wr_mode = wr_en && wb_adr_i == REG_MODE   && wb_sel_i[0];
    wire wr_opts = wr_en && wb_adr_i == REG_OPTS   && wb_sel_i[0];
    wire wr_sp   = wr_en && wb_adr_i == REG_SLEEP  && wb_sel_i[1:0] == 2'b11;
    wire wr_st   = wr_en && wb_adr_i == REG_WAKE   && wb_sel_i[1:0] == 2'b11;
    wire wr_ser  = wr_en && wb_adr_i == REG_SERIAL && wb_sel_i[1:0] == 2'b11;
    wire [15:0] wr16 = wb_dat_i[15:0];
    // differing from the operating values counts as a network change
    wire par_chg = compat && !noncoord &&
                   ((wr_sp && wr16 != osp_q) || (wr_st && wr16 != owk_q));

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (wb_adr_i)
            REG_MODE:    rd_mux = {28'h000_0000, mode_q};
            REG_OPTS:    rd_mux = {28'h000_0000, opts_q};
            REG_SLEEP:   rd_mux = {16'h0000, sp_q};
            REG_WAKE:    rd_mux = {16'h0000, st_q};
            REG_OPSLEEP: rd_mux = {16'h0000, osp_q};
            REG_OPWAKE:  rd_mux = {16'h0000, owk_q};
            REG_STATUS:  rd_mux = {24'h00_0000, gen_q[1:0], state_q, pending_q,
                                   synced_q, awake_o, coord_q};
            REG_MISSED:  rd_mux = {24'h00_0000, missed_q};
            REG_SERIAL:  rd_mux = {16'h0000, serial_q};
            default:     rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_mux : wb_dat_o;
        end
    end

    // configuration store
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mode_q   <= RST_MODE;
            opts_q   <= RST_OPTS;                                        // early wake on by default
            sp_q     <= RST_SLEEP;
            st_q     <= RST_WAKE;
            serial_q <= 16'h0000;
        end else begin
            if (wr_mode) mode_q <= wb_dat_i[3:0];
            if (wr_opts) opts_q <= wb_dat_i[3:0];
            if (wr_sp) sp_q <= wr16;
            if (wr_st) st_q <= wr16;
            if (wr_ser) serial_q <= wr16;
        end
    end

    // local timebase tick
    logic [31:0] pre_q;
    wire tick = (pre_q == 32'(TICK_CYCLES - 1));
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) pre_q <= 32'h0000_0000;
        else pre_q <= tick ? 32'h0000_0000 : pre_q + 32'h0000_0001;
    end

    // claim arbitration against an incoming coordinator sync
    function automatic logic rx_wins(input logic [7:0] rg, input logic rp, input logic rs,
                                     input logic [15:0] rser, input logic [7:0] mg,
                                     input logic mp, input logic ms, input logic [15:0] mser);
        if (rg != mg) return (rg - mg) < 8'h80;                          // newer params first
        if (rp != mp) return rp;
        if (rs != ms) return rs;
        return rser > mser;
    endfunction

    wire sync_new = rx_sync_i && rx_gen_i != gen_q;
    wire rx_old   = sync_new && (gen_q - rx_gen_i) < 8'h80;             // older settings
    wire reject   = support && synced_q && rx_old;
    wire yield    = rx_sync_coord_i && coord_q &&
                    rx_wins(rx_gen_i, rx_pref_i, rx_support_i, rx_serial_i,
                            gen_q, pref, support, serial_q);
    wire accept   = rx_sync_i && compat && !reject && (!coord_q || yield || !rx_sync_coord_i);

    // early wake: sleep trimmed by one eighth per missed cycle, floored at one tick
    wire [15:0] trim     = 16'((32'(osp_q) * 32'(missed_q)) >> 3);
    wire [15:0] sleep_ld = (!opts_q[OPT_NOEARLY] && trim < osp_q) ?
                           (osp_q - trim) : ((!opts_q[OPT_NOEARLY]) ? 16'h0001 : osp_q);

    // phase sequencer
    logic [15:0] cnt_q;
    logic [31:0] hold_q;
    wire hold_on  = (hold_q != 32'h0000_0000);
    wire phase_end = tick && cnt_q == 16'h0000;

    // wake start: leaving sleep, or the single cycle of entering from normal
    logic       awake_p_q;
    wire        awake_now  = state_q != ST_SLEEP;
    wire        wake_start = compat && ((awake_now && !awake_p_q) || state_q == ST_NORMAL);
    // flagged one tick ahead so the status frame still goes out while awake
    wire        sleep_next = state_q == ST_WAKE && tick && cnt_q == 16'h0001 && cyclic && !hold_on;
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q  <= ST_NORMAL;
            cnt_q    <= 16'h0000;
            hold_q   <= 32'h0000_0000;
            osp_q    <= RST_SLEEP;
            owk_q    <= RST_WAKE;
            gen_q    <= 8'h00;
            missed_q <= 8'h00;
            synced_q <= 1'b0;
            coord_q  <= 1'b0;
            pending_q <= 1'b0;
        end else begin
            if (hold && cyclic) hold_q <= 32'(HOLD_TICKS);
            else if (tick && hold_on) hold_q <= hold_q - 32'h0000_0001;
            if (par_chg) begin
                coord_q   <= 1'b1;
                pending_q <= 1'b1;                                       // sent at next wake
            end else if (press2 && !noncoord && compat) coord_q <= 1'b1;
            else if (pref && compat) coord_q <= 1'b1;
            else if (yield) coord_q <= 1'b0;
            else if (!compat) coord_q <= 1'b0;
            if (accept) begin
                osp_q    <= rx_sleep_i;
                owk_q    <= rx_wake_i;
                gen_q    <= rx_gen_i;
                missed_q <= 8'h00;
                synced_q <= 1'b1;
                if (!par_chg) pending_q <= 1'b0;                         // a fresh change wins
            end
            case (state_q)
                ST_NORMAL: begin
                    if (compat) begin
                        state_q <= ST_WAKE;
                        cnt_q   <= owk_q;
                    end
                end
                ST_WAKE: begin
                    if (!compat) state_q <= ST_NORMAL;
                    else if (tick && cnt_q != 16'h0000) cnt_q <= cnt_q - 16'h0001;
                    else if (phase_end && cyclic && !hold_on) begin
                        state_q <= ST_SLEEP;
                        cnt_q   <= sleep_ld;
                    end else if (phase_end) cnt_q <= owk_q;
                end
                ST_SLEEP: begin
                    if (!compat) state_q <= ST_NORMAL;
                    else if ((press1 && synced_q) || (hold && cyclic)) begin
                        state_q <= ST_WAKE;
                        cnt_q   <= owk_q;
                    end else if (tick && cnt_q != 16'h0000) cnt_q <= cnt_q - 16'h0001;
                    else if (phase_end) begin
                        state_q <= ST_WAKE;
                        cnt_q   <= owk_q;
                        if (!coord_q && missed_q != 8'hFF) missed_q <= missed_q + 8'h01;
                        if (!coord_q && missed_q >= 8'h01) synced_q <= 1'b0;
                        if (!noncoord && missed_q + 8'h01 >= MISS_NOMINATE) begin
                            coord_q <= 1'b1;
                        end
                    end
                end
                default: state_q <= ST_NORMAL;
            endcase
            // a missed update simply leaves osp_q and owk_q as they were
            if (pending_q && wake_start) begin
                osp_q     <= sp_q;
                owk_q     <= st_q;
                gen_q     <= gen_q + 8'h01;
                pending_q <= 1'b0;
            end
        end
    end

    // outgoing messages, registered pulses
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            awake_p_q    <= 1'b0;
            tx_req_o     <= 1'b0;
            tx_sync_o    <= 1'b0;
            tx_sleep_o   <= 16'h0000;
            tx_wake_o    <= 16'h0000;
            tx_gen_o     <= 8'h00;
            stat_wake_o  <= 1'b0;
            stat_sleep_o <= 1'b0;
        end else begin
            awake_p_q    <= awake_now;
            tx_req_o     <= wake_start && !synced_q && !coord_q;
            tx_sync_o    <= (wake_start && coord_q) ||
                            (rx_req_i && awake_now && compat && (synced_q || coord_q)) ||
                            reject;
            tx_sleep_o   <= (wake_start && pending_q) ? sp_q : osp_q;
            tx_wake_o    <= (wake_start && pending_q) ? st_q : owk_q;
            tx_gen_o     <= (wake_start && pending_q) ? gen_q + 8'h01 : gen_q;
            stat_wake_o  <= opts_q[OPT_STATMSG] && wake_start && cyclic;
            stat_sleep_o <= opts_q[OPT_STATMSG] && sleep_next;
        end
    end

    // indicator: slow for coordinator, fast when synced and awake
    logic [7:0] blk_q;
    logic       led_q;
    wire [7:0]  blk_lim = coord_q ? 8'(BLINK_SLOW_TK) : 8'(BLINK_FAST_TK);
    wire        led_run = compat && awake_now && (coord_q || synced_q);
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            blk_q <= 8'h00;
            led_q <= 1'b0;
        end else if (!led_run) begin
            blk_q <= 8'h00;
            led_q <= 1'b0;
        end else if (tick) begin
            blk_q <= (blk_q >= blk_lim - 8'h01) ? 8'h00 : blk_q + 8'h01;
            led_q <= (blk_q >= blk_lim - 8'h01) ? ~led_q : led_q;
        end
    end

    assign awake_o = awake_now;
    assign led_o   = led_q;
endmodule

/* hdl/ssc_pkg.sv */
package ssc_pkg;
    // register byte offsets on the wishbone bus
    localparam logic [7:0] REG_MODE    = 8'h00;
    localparam logic [7:0] REG_OPTS    = 8'h04;
    localparam logic [7:0] REG_SLEEP   = 8'h08;
    localparam logic [7:0] REG_WAKE    = 8'h0C;
    localparam logic [7:0] REG_OPSLEEP = 8'h10;
    localparam logic [7:0] REG_OPWAKE  = 8'h14;
    localparam logic [7:0] REG_STATUS  = 8'h18;
    localparam logic [7:0] REG_MISSED  = 8'h1C;
    localparam logic [7:0] REG_SERIAL  = 8'h20;

    // sleep mode values
    localparam logic [3:0] MODE_NORMAL  = 4'h0;
    localparam logic [3:0] MODE_SUPPORT = 4'h7;
    localparam logic [3:0] MODE_CYCLIC  = 4'h8;

    // option bit positions
    localparam int OPT_PREF    = 0;
    localparam int OPT_NONCOORD = 1;
    localparam int OPT_NOEARLY = 2;
    localparam int OPT_STATMSG = 3;

    // reset values and the nomination threshold
    localparam logic [3:0]  RST_MODE   = MODE_NORMAL;
    localparam logic [3:0]  RST_OPTS   = 4'h0;
    localparam logic [15:0] RST_SLEEP  = 16'h0064;
    localparam logic [15:0] RST_WAKE   = 16'h00C8;
    localparam logic [7:0]  MISS_NOMINATE = 8'h03;

    // timing
    localparam int CLK_HZ        = 50_000_000;
    localparam int TICK_US       = 10_000;   // timebase tick, 10 ms
    localparam int TICK_CYC      = CLK_HZ / 1_000_000 * TICK_US;
    localparam int AWAKE_HOLD_S  = 30;
    localparam int AWAKE_TICKS   = AWAKE_HOLD_S * 1_000_000 / TICK_US;
    localparam int BLINK_FAST_TK = 25;
    localparam int BLINK_SLOW_TK = 100;

    typedef enum logic [1:0] {
        ST_NORMAL = 2'b00,
        ST_WAKE   = 2'b01,
        ST_SLEEP  = 2'b11
    } ssc_state_t;
endpackage

/* verification/ssc_props.sv */
`timescale 1ns/1ns
// port-level checks of the sleep sync controller
module ssc_props (
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        tx_req_o,
    input wire logic        tx_sync_o,
    input wire logic        stat_wake_o,
    input wire logic        stat_sleep_o,
    input wire logic        awake_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // bus answer comes one cycle after the request is taken, and only once
    ack_prompt_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered in one cycle");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("bus ack without request");
    // read data only moves together with an ack, so software sees a steady value
    data_hold_a: assert property (!wb_ack_o |-> $stable(wb_dat_o))
        else $error("read data changed without ack");
    unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h23 |-> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    // requests go out only while awake, as single pulses; syncs go out only while awake
    req_awake_a: assert property (tx_req_o |-> awake_o ##1 !tx_req_o)
        else $error("sync request while asleep or too long");
    sync_awake_a: assert property (tx_sync_o |-> awake_o)
        else $error("sync sent while asleep");
    stat_wake_a: assert property ($rose(stat_wake_o) |-> awake_o ##1 !stat_wake_o)
        else $error("wake status frame wrong");
    stat_sleep_a: assert property ($rose(stat_sleep_o) |-> awake_o)
        else $error("sleep status frame after sleeping");
endmodule

bind ssc_top ssc_props ssc_props_i (.clk_i, .resetn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
    .wb_ack_o, .tx_req_o, .tx_sync_o, .stat_wake_o, .stat_sleep_o, .awake_o);

/* verification/ssc_peer.sv */
`timescale 1ns/1ns
// far-side peer node: answers our sync requests, asks for a sync on command
module ssc_peer #(
    parameter int          DELAY   = 3,
    parameter logic [15:0] P_SLEEP = 16'h0006,
    parameter logic [15:0] P_WAKE  = 16'h0005,
    parameter logic [7:0]  P_GEN   = 8'h10,
    parameter logic [15:0] P_SER   = 16'h5A3C  // arbitrary serial value
) (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        tx_req_i,
    input  wire logic        ask_i,
    output logic             req_o,
    output logic             sync_o,
    output logic             coord_o,
    output logic      [15:0] sleep_o,
    output logic      [15:0] wake_o,
    output logic      [7:0]  gen_o,
    output logic             pref_o,
    output logic             support_o,
    output logic      [15:0] serial_o
);
    logic [7:0] cnt_q;

    // answer a request DELAY cycles later; a slow peer is only a larger DELAY
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q  <= 8'h00;
            req_o  <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            req_o  <= ask_i;
            sync_o <= (cnt_q == 8'h01);
            if (tx_req_i)
                cnt_q <= 8'(DELAY);
            else if (cnt_q != 8'h00)
                cnt_q <= cnt_q - 8'h01;
        end
    end

    // fields mean something only with the sync pulse; otherwise the inverse shows
    assign sleep_o   = sync_o ? P_SLEEP : ~P_SLEEP;
    assign wake_o    = sync_o ? P_WAKE : ~P_WAKE;
    assign gen_o     = sync_o ? P_GEN : ~P_GEN;
    assign serial_o  = sync_o ? P_SER : ~P_SER;
    assign coord_o   = sync_o;
    assign pref_o    = ~sync_o;
    assign support_o = ~sync_o;
endmodule

/* verification/ssc_top_tb.sv */
`timescale 1ns/1ns
// self-checking bench of the sleep sync controller
module ssc_top_tb;
    import ssc_pkg::*;
    logic        clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic        btn_single_i = 1'b0;
    logic        btn_double_i = 1'b0;
    logic        ask = 1'b0;
    logic        rx_req_i, rx_sync_i, rx_sync_coord_i, rx_pref_i, rx_support_i;
    logic [15:0] rx_sleep_i, rx_wake_i, rx_serial_i;
    logic [7:0]  rx_gen_i;
    logic [31:0] wb_dat_o;
    logic [31:0] rd;
    logic        wb_ack_o, tx_req_o, tx_sync_o, awake_o, led_o;
    int          mismatches = 0;
    int          n_checks = 0;
    int          bad;

    // 50 MHz clock
    always #10 clk_i = ~clk_i;

    ssc_peer ssc_peer_i (.clk_i, .resetn_i, .tx_req_i(tx_req_o), .ask_i(ask), .req_o(rx_req_i), .sync_o(rx_sync_i),
        .coord_o(rx_sync_coord_i), .sleep_o(rx_sleep_i), .wake_o(rx_wake_i), .gen_o(rx_gen_i), .pref_o(rx_pref_i),
        .support_o(rx_support_i), .serial_o(rx_serial_i));

    // short tick so that sleep and wake phases last tens of cycles
    ssc_top #(.TICK_CYCLES(4), .HOLD_TICKS(20)) ssc_top_i (.clk_i, .resetn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .btn_single_i, .btn_double_i, .btn_hold_i(1'b0),
        .rx_req_i, .rx_sync_i, .rx_sync_coord_i, .rx_sleep_i, .rx_wake_i, .rx_gen_i, .rx_pref_i, .rx_support_i,
        .rx_serial_i, .tx_req_o, .tx_sync_o, .tx_sleep_o(), .tx_wake_o(), .tx_gen_o(), .stat_wake_o(),
        .stat_sleep_o(), .awake_o, .led_o);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // one classic cycle; holds everything until ack is sampled, then releases
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        while (wb_ack_o !== 1'b1) begin
            @(posedge clk_i);
            n++;
            if (n > 40)
                print_verdict_on_hang();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic print_verdict_on_hang();
        mismatches++;
        print_verdict();
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: pick = awake_o;
            1: pick = tx_req_o;
            2: pick = tx_sync_o;
            default: pick = rx_sync_i;
        endcase
    endfunction

    // bounded wait for one watched signal to reach a level
    task automatic wait_on(input int s, input logic v, input int lim);
        int n;
        n = 0;
        while (pick(s) !== v) begin
            @(posedge clk_i);
            n++;
            if (n > lim)
                print_verdict_on_hang();
        end
    endtask

    // main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        bad = 0;
        repeat (100) begin
            @(posedge clk_i);
            bad += int'(awake_o !== 1'b1 || tx_req_o !== 1'b0 || led_o !== 1'b0);
        end
        check(bad, 0);
        rdchk(REG_MODE, 32'(MODE_NORMAL));
        rdchk(REG_OPTS, 32'(RST_OPTS));
        rdchk(REG_SLEEP, 32'(RST_SLEEP));
        rdchk(REG_WAKE, 32'(RST_WAKE));
        xfer(1'b1, 8'h40, 32'hFFFF_FFFF);
        rdchk(8'h40, 32'h0000_0000);
        // status frames on, then synchronous cyclic sleep: an unsynced node asks
        xfer(1'b1, REG_OPTS, 32'h0000_0008);
        xfer(1'b1, REG_MODE, 32'(MODE_CYCLIC));
        wait_on(1, 1'b1, 3000);
        wait_on(3, 1'b1, 20);
        repeat (2) @(posedge clk_i);
        // a peer request reaches us one cycle after ask; answer one cycle later
        ask <= 1'b1;
        @(posedge clk_i);
        ask <= 1'b0;
        repeat (2) @(posedge clk_i);
        check(tx_sync_o, 1'b1);
        rdchk(REG_OPSLEEP, 32'h0000_0006);
        rdchk(REG_OPWAKE, 32'h0000_0005);
        rdchk(REG_MISSED, 32'h0000_0000);
        xfer(1'b0, REG_STATUS, 32'h0000_0000);
        check(rd[2], 1'b1);
        // asleep and synced: one press wakes the node well before its period ends
        wait_on(0, 1'b0, 3000);
        btn_single_i <= 1'b1;
        wait_on(0, 1'b1, 12);
        btn_single_i <= 1'b0;
        btn_double_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        btn_double_i <= 1'b0;
        xfer(1'b0, REG_STATUS, 32'h0000_0000);
        check(rd[0], 1'b1);
        wait_on(2, 1'b1, 3000);
        // sleep support: the node never sleeps
        xfer(1'b1, REG_MODE, 32'(MODE_SUPPORT));
        repeat (4) @(posedge clk_i);
        bad = 0;
        repeat (300) begin
            @(posedge clk_i);
            bad += int'(awake_o !== 1'b1);
        end
        check(bad, 0);
        print_verdict();
    end
endmodule
